// >>> demux_host_com_area_port.v
// Demultiplexed host port into the host/processor communication area
`timescale 1ns/1ps
`include "com_area_regs.vh"

// Functional notes
// (RQ1) Address on four address pins, data on eight data pins, no address phase.
// (RQ2) Three low address pins select eight directly mapped locations.
// (RQ3) Fourth pin adds indirect locations reaching the whole communication area; location 09 reaches only the eight mapped target addresses.
// (RQ4) Direct locations decode only to the mirrored communication registers.
// (RQ5) Host writes target address to location 08 before using location 09.
// (RQ6) Location 09 reads the target location; writes update it.
// (RQ7) Locations 00-07 behave exactly like their multiplexed counterparts.
// (RQ8) Locations 0A-0F reserved: writes ignored, reads return zero.
// (RQ9) Each mailbox I/O access increments its pointer, wrapping to zero.
// (RQ10) Host soft interrupt write raises processor status and sets busy bit.
module demux_host_com_area_port (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Host bus pins
	input wire cs_n_pin,
	input wire rd_n_pin,
	input wire wr_n_pin,
	input wire [2:0] addr_low_pin,
	input wire indirect_select_pin,
	input wire [7:0] ad_in,
	output wire [7:0] ad_out,
	output wire ad_oe,
	// Processor side mailbox
	input wire dsp_mbx_wr,
	input wire [7:0] dsp_mbx_waddr,
	input wire [7:0] dsp_mbx_wdata,
	input wire [7:0] dsp_mbx_raddr,
	output wire [7:0] dsp_mbx_rdata,
	// Processor side soft interrupts
	input wire dsp_h2p_ack,
	input wire dsp_h2p_busy_clr,
	input wire dsp_p2h_wr,
	input wire [7:0] dsp_p2h_vec,
	output wire host_to_proc_soft_irq,
	output wire [7:0] h2p_vec,
	output wire host_irq_busy_flag,
	output wire proc_irq_busy_flag,
	output wire dint_status,
	// Control words and interrupt high byte
	input wire [7:0] dsp_ctrl_lo,
	input wire [7:0] dsp_ctrl_hi,
	input wire [7:0] irq_status_high,
	output wire [7:0] ctrl_h2d_lo,
	output wire [7:0] ctrl_h2d_hi,
	output wire [7:0] irq_mask_high
);

	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	reg [`PIN_W-1:0] sync1_ff;
	reg [`PIN_W-1:0] sync2_ff;
	reg [`PIN_W-1:0] sync3_ff;
	reg [`PIN_W-1:0] flt_ff;
	reg rd_act_ff;
	reg wr_act_ff;
	reg [3:0] wr_loc_ff;
	reg [7:0] wr_data_ff;
	reg [7:0] rd_ma_ff;
	reg [7:0] tgt_addr_ff;
	reg [7:0] ad_out_ff;
	reg ad_oe_ff;
	reg [7:0] mbx_rd_ptr_ff;
	reg [7:0] mbx_wr_ptr_ff;
	reg [7:0] h2p_vec_ff;
	reg h2p_irq_ff;
	reg h2p_busy_ff;
	reg [7:0] p2h_vec_ff;
	reg dint_ff;
	reg p2h_busy_ff;
	reg [7:0] ctrl_lo_ff;
	reg [7:0] ctrl_hi_ff;
	reg [7:0] mask_hi_ff;
	reg [7:0] dsp_rdata_ff;
	wire rd_act;
	wire wr_act;
	wire rd_start;
	wire rd_end;
	wire wr_end;
	wire [3:0] pin_loc;
	wire [7:0] w_ma;
	wire wr_go;
	wire h_mbx_rd;
	wire h_p2h_rd;
	wire h_mbx_wr;
	wire [7:0] h2d_rdata;
	wire [7:0] d2h_rdata;

	// --------------------------------------------------------------------
	// Decode helpers
	// --------------------------------------------------------------------
	// Local location to target address; 08 is handled by the caller
	function [7:0] map_addr;
		input [3:0] loc;
		input [7:0] tgt;
		begin
			case (loc)
				`LOC_MBX_RD_PTR: map_addr = `MA_MBX_RD_PTR; // RQ4
				`LOC_MBX_WR_PTR: map_addr = `MA_MBX_WR_PTR; // RQ4
				`LOC_MBX_IO: map_addr = `MA_MBX_IO; // RQ4
				`LOC_H2P_IRQ: map_addr = `MA_H2P_IRQ; // RQ4
				`LOC_P2H_IRQ: map_addr = `MA_P2H_IRQ; // RQ4
				`LOC_CTRL_LO: map_addr = `MA_CTRL_LO; // RQ4
				`LOC_CTRL_HI: map_addr = `MA_CTRL_HI; // RQ4
				`LOC_MASK_HI: map_addr = `MA_MASK_HI; // RQ4
				`LOC_IND_DATA: map_addr = tgt; // RQ6
				default: map_addr = `MA_NONE; // RQ8
			endcase
		end
	endfunction

	// Read value of a target address; unmapped targets read zero
	function [7:0] rd_val;
		input [7:0] ma;
		begin
			case (ma)
				`MA_MBX_RD_PTR: rd_val = mbx_rd_ptr_ff;
				`MA_MBX_WR_PTR: rd_val = mbx_wr_ptr_ff;
				`MA_MBX_IO: rd_val = d2h_rdata;
				`MA_H2P_IRQ: rd_val = {7'h00, h2p_busy_ff};
				`MA_P2H_IRQ: rd_val = p2h_vec_ff;
				`MA_CTRL_LO: rd_val = dsp_ctrl_lo;
				`MA_CTRL_HI: rd_val = dsp_ctrl_hi;
				`MA_MASK_HI: rd_val = irq_status_high;
				default: rd_val = `RD_ZERO; // RQ8
			endcase
		end
	endfunction

	// --------------------------------------------------------------------
	// Pin synchroniser and filter
	// --------------------------------------------------------------------
	// A bit of the filtered copy moves only when stages two and three agree
	always @(posedge mclk) begin
		if (sys_rst) begin
			sync1_ff <= {`PIN_W{1'b1}};
			sync2_ff <= {`PIN_W{1'b1}};
			sync3_ff <= {`PIN_W{1'b1}};
			flt_ff <= {`PIN_W{1'b1}};
		end else begin
			sync1_ff <= {cs_n_pin, rd_n_pin, wr_n_pin, indirect_select_pin,
				addr_low_pin, ad_in}; // RQ1
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			flt_ff <= (sync2_ff & sync3_ff) | (flt_ff & (sync2_ff ^ sync3_ff));
		end
	end

	assign rd_act = ~flt_ff[`PIN_CS] & ~flt_ff[`PIN_RD];
	assign wr_act = ~flt_ff[`PIN_CS] & ~flt_ff[`PIN_WR];
	assign rd_start = rd_act & ~rd_act_ff;
	assign rd_end = ~rd_act & rd_act_ff;
	assign wr_end = ~wr_act & wr_act_ff;
	assign pin_loc = flt_ff[11:8]; // RQ2 RQ3

	// --------------------------------------------------------------------
	// Access tracking
	// --------------------------------------------------------------------
	// Write data is taken each cycle of the strobe and used at its end,
	// so a slow host that settles data late is still caught correctly
	always @(posedge mclk) begin
		if (sys_rst) begin
			rd_act_ff <= `RST_BIT;
			wr_act_ff <= `RST_BIT;
			wr_loc_ff <= 4'h0;
			wr_data_ff <= `RST_BYTE;
			rd_ma_ff <= `MA_NONE;
		end else begin
			rd_act_ff <= rd_act;
			wr_act_ff <= wr_act;
			if (wr_act) begin
				wr_loc_ff <= pin_loc; // RQ1
				wr_data_ff <= flt_ff[7:0]; // RQ1
			end
			if (rd_start) begin
				if (pin_loc == `LOC_IND_ADDR) begin
					rd_ma_ff <= `MA_NONE;
				end else begin
					rd_ma_ff <= map_addr(pin_loc, tgt_addr_ff); // RQ6
				end
			end
		end
	end

	// --------------------------------------------------------------------
	// Read data drive
	// --------------------------------------------------------------------
	always @(posedge mclk) begin
		if (sys_rst) begin
			ad_out_ff <= `RST_BYTE;
			ad_oe_ff <= `RST_BIT;
		end else if (rd_start) begin
			ad_oe_ff <= 1'b1;
			if (pin_loc == `LOC_IND_ADDR) begin
				ad_out_ff <= tgt_addr_ff; // RQ5
			end else begin
				ad_out_ff <= rd_val(map_addr(pin_loc, tgt_addr_ff)); // RQ6 RQ7
			end
		end else if (rd_end) begin
			ad_oe_ff <= 1'b0;
		end
	end

	// --------------------------------------------------------------------
	// Write decode and side effects
	// --------------------------------------------------------------------
	assign w_ma = map_addr(wr_loc_ff, tgt_addr_ff);
	assign wr_go = wr_end & (wr_loc_ff != `LOC_IND_ADDR);
	// Side effects fire at the end of a read, after the data was sampled
	assign h_mbx_rd = rd_end & (rd_ma_ff == `MA_MBX_IO); // RQ9
	assign h_p2h_rd = rd_end & (rd_ma_ff == `MA_P2H_IRQ); // RQ7
	assign h_mbx_wr = wr_go & (w_ma == `MA_MBX_IO); // RQ9

	always @(posedge mclk) begin
		if (sys_rst) begin
			tgt_addr_ff <= `RST_BYTE;
		end else if (wr_end && wr_loc_ff == `LOC_IND_ADDR) begin
			tgt_addr_ff <= wr_data_ff; // RQ5
		end
	end

	// Mailbox pointers; 8-bit counters wrap from the top back to zero
	always @(posedge mclk) begin
		if (sys_rst) begin
			mbx_rd_ptr_ff <= `RST_BYTE;
			mbx_wr_ptr_ff <= `RST_BYTE;
		end else begin
			if (wr_go && w_ma == `MA_MBX_RD_PTR) begin
				mbx_rd_ptr_ff <= wr_data_ff; // RQ7
			end else if (h_mbx_rd) begin
				mbx_rd_ptr_ff <= mbx_rd_ptr_ff + 8'h01; // RQ9
			end
			if (wr_go && w_ma == `MA_MBX_WR_PTR) begin
				mbx_wr_ptr_ff <= wr_data_ff; // RQ7
			end else if (h_mbx_wr) begin
				mbx_wr_ptr_ff <= mbx_wr_ptr_ff + 8'h01; // RQ9
			end
		end
	end

	// Soft interrupts; a set in the same cycle as a clear wins
	always @(posedge mclk) begin
		if (sys_rst) begin
			h2p_vec_ff <= `RST_BYTE;
			h2p_irq_ff <= `RST_BIT;
			h2p_busy_ff <= `RST_BIT;
			p2h_vec_ff <= `RST_BYTE;
			dint_ff <= `RST_BIT;
			p2h_busy_ff <= `RST_BIT;
		end else begin
			if (wr_go && w_ma == `MA_H2P_IRQ) begin
				h2p_vec_ff <= wr_data_ff; // RQ10
				h2p_irq_ff <= 1'b1; // RQ10
				h2p_busy_ff <= 1'b1; // RQ10
			end else begin
				if (dsp_h2p_ack) begin
					h2p_irq_ff <= 1'b0;
				end
				if (dsp_h2p_busy_clr) begin
					h2p_busy_ff <= 1'b0;
				end
			end
			if (dsp_p2h_wr) begin
				p2h_vec_ff <= dsp_p2h_vec;
				dint_ff <= 1'b1;
				p2h_busy_ff <= 1'b1;
			end else begin
				if (h_p2h_rd) begin
					dint_ff <= 1'b0; // RQ7
				end
				if (wr_go && w_ma == `MA_P2H_IRQ) begin
					p2h_busy_ff <= wr_data_ff[`BUSY_BIT]; // RQ7
				end
			end
		end
	end

	// Control words and interrupt mask high byte
	always @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_lo_ff <= `RST_BYTE;
			ctrl_hi_ff <= `RST_BYTE;
			mask_hi_ff <= `RST_BYTE;
		end else if (wr_go) begin
			case (w_ma)
				`MA_CTRL_LO: ctrl_lo_ff <= wr_data_ff; // RQ7
				`MA_CTRL_HI: ctrl_hi_ff <= wr_data_ff; // RQ7
				`MA_MASK_HI: mask_hi_ff <= wr_data_ff; // RQ7
				default: mask_hi_ff <= mask_hi_ff; // RQ8
			endcase
		end
	end

	// --------------------------------------------------------------------
	// Mailbox halves
	// --------------------------------------------------------------------
	mbx_ram u_h2d_mbx (
		.mclk(mclk),
		.wr_en(h_mbx_wr),
		.wr_addr(mbx_wr_ptr_ff),
		.wr_data(wr_data_ff),
		.rd_addr(dsp_mbx_raddr),
		.rd_data(h2d_rdata)
	);

	mbx_ram u_d2h_mbx (
		.mclk(mclk),
		.wr_en(dsp_mbx_wr),
		.wr_addr(dsp_mbx_waddr),
		.wr_data(dsp_mbx_wdata),
		.rd_addr(mbx_rd_ptr_ff),
		.rd_data(d2h_rdata)
	);

	always @(posedge mclk) begin
		if (sys_rst) begin
			dsp_rdata_ff <= `RST_BYTE;
		end else begin
			dsp_rdata_ff <= h2d_rdata;
		end
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	assign ad_out = ad_out_ff;
	assign ad_oe = ad_oe_ff;
	assign dsp_mbx_rdata = dsp_rdata_ff;
	assign host_to_proc_soft_irq = h2p_irq_ff;
	assign h2p_vec = h2p_vec_ff;
	assign host_irq_busy_flag = h2p_busy_ff;
	assign proc_irq_busy_flag = p2h_busy_ff;
	assign dint_status = dint_ff;
	assign ctrl_h2d_lo = ctrl_lo_ff;
	assign ctrl_h2d_hi = ctrl_hi_ff;
	assign irq_mask_high = mask_hi_ff;

endmodule // demux_host_com_area_port

// >>> com_area_regs.vh
// Register locations, target addresses and reset values of the com area
`ifndef COM_AREA_REGS_VH
`define COM_AREA_REGS_VH

// --------------------------------------------------------------------
// Direct locations 00-07 and indirect locations 08-09 on the four address pins
// --------------------------------------------------------------------
`define LOC_MBX_RD_PTR 4'h0
`define LOC_MBX_WR_PTR 4'h1
`define LOC_MBX_IO 4'h2
`define LOC_H2P_IRQ 4'h3
`define LOC_P2H_IRQ 4'h4
`define LOC_CTRL_LO 4'h5
`define LOC_CTRL_HI 4'h6
`define LOC_MASK_HI 4'h7
`define LOC_IND_ADDR 4'h8
`define LOC_IND_DATA 4'h9

// --------------------------------------------------------------------
// Target addresses in the multiplexed map
// --------------------------------------------------------------------
`define MA_MBX_RD_PTR 8'h48
`define MA_MBX_WR_PTR 8'h4a
`define MA_MBX_IO 8'h4c
`define MA_H2P_IRQ 8'h50
`define MA_P2H_IRQ 8'h58
`define MA_CTRL_LO 8'h60
`define MA_CTRL_HI 8'h61
`define MA_MASK_HI 8'h75
`define MA_NONE 8'hff

// --------------------------------------------------------------------
// Reset values and field positions
// --------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_BIT 1'b0
`define RD_ZERO 8'h00
`define BUSY_BIT 0
`define PIN_CS 14
`define PIN_RD 13
`define PIN_WR 12
`define PIN_W 15

`endif

// >>> mbx_ram.v
// One 256-byte mailbox half: one write port, one read port
`timescale 1ns/1ps

module mbx_ram (
	// Clock
	input wire mclk,
	// Write side
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [7:0] wr_data,
	// Read side
	input wire [7:0] rd_addr,
	output wire [7:0] rd_data
);

	reg [7:0] mem [0:255];

	// --------------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------------
	// Contents are not reset; software always writes before reading
	always @(posedge mclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];

endmodule // mbx_ram

// >>> com_area_props_properties.sv
// Assertions on the demultiplexed host port
`timescale 1ns/1ps
module com_area_props (
	// Clock and reset
	input wire mclk,
	input wire sys_rst,
	// Host pins
	input wire cs_n_pin,
	input wire rd_n_pin,
	input wire wr_n_pin,
	input wire [2:0] addr_low_pin,
	input wire indirect_select_pin,
	input wire ad_oe,
	// Processor side
	input wire dsp_h2p_ack,
	input wire dsp_h2p_busy_clr,
	input wire dsp_p2h_wr,
	input wire host_to_proc_soft_irq,
	input wire host_irq_busy_flag,
	input wire proc_irq_busy_flag,
	input wire dint_status
);
// ----
// Strobe decode and checks
// ----
// Raw pin levels; the five-edge figures below include the synchroniser
wire rd_act = !cs_n_pin && !rd_n_pin;
wire wr_act = !cs_n_pin && !wr_n_pin;
wire [3:0] loc = {indirect_select_pin, addr_low_pin};
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
a_oe_rise: assert property ($rose(rd_act) |-> ##5 ad_oe)
	else $error("read data not driven on time");
a_oe_drop: assert property ($fell(rd_act) |-> ##4 ad_oe ##1 !ad_oe)
	else $error("read data not released on time");
a_idle_quiet: assert property (!rd_act [*6] |-> !ad_oe)
	else $error("data pins driven without a read");
a_soft_raise: assert property ($fell(wr_act) && loc == 4'h3 |->
	##5 host_to_proc_soft_irq && host_irq_busy_flag)
	else $error("soft interrupt not raised after write");
a_dint_clear: assert property ($fell(rd_act) && loc == 4'h4 |->
	##5 !dint_status)
	else $error("status not cleared by vector read");
a_ind_set: assert property (dsp_p2h_wr |=> dint_status && proc_irq_busy_flag)
	else $error("vector load did not set status and busy");
a_ack_clear: assert property ((cs_n_pin [*6] ##0 dsp_h2p_ack) |=>
	!host_to_proc_soft_irq)
	else $error("acknowledge did not clear soft interrupt");
a_busy_clear: assert property ((cs_n_pin [*6] ##0 dsp_h2p_busy_clr) |=>
	!host_irq_busy_flag)
	else $error("busy flag not cleared");
c_read: cover property ($rose(ad_oe));
c_soft: cover property ($rose(host_to_proc_soft_irq));
c_dint: cover property ($fell(dint_status));
endmodule // com_area_props

// >>> host_bus_model.sv
// Host processor model on the demultiplexed bus
`timescale 1ns/1ps
module host_bus_model (
	// Clock
	input wire mclk,
	// Bus pins
	output reg cs_n_pin = 1'b1,
	output reg rd_n_pin = 1'b1,
	output reg wr_n_pin = 1'b1,
	output reg [2:0] addr_low_pin = 3'h0,
	output reg indirect_select_pin = 1'b0,
	output wire [7:0] ad_in,
	input wire [7:0] ad_out,
	input wire ad_oe,
	// Answer never came
	output reg hang = 1'b0
);
// ----
// One byte access
// ----
reg [7:0] drv = 8'h00;
integer n;
// Released data shows inverted, so a stale byte cannot pass
assign ad_in = ad_oe ? ad_out : drv;
task access(input w, input [3:0] l, input [7:0] v, output [7:0] q);
	begin
		addr_low_pin <= l[2:0];
		indirect_select_pin <= l[3];
		if (w) drv <= v;
		repeat (2) @(posedge mclk);
		cs_n_pin <= 1'b0;
		rd_n_pin <= w;
		wr_n_pin <= !w;
		n = 0;
		while (!w && ad_oe !== 1'b1 && n < 12) begin
			@(posedge mclk);
			n = n + 1;
		end
		if (w) repeat (6) @(posedge mclk);
		if (n == 12) hang <= 1'b1;
		q = ad_out;
		{cs_n_pin, rd_n_pin, wr_n_pin} <= 3'h7;
		// Data held past the strobe; the end is seen four edges late
		repeat (4) @(posedge mclk);
		drv <= ~drv;
		repeat (2) @(posedge mclk);
	end
endtask
endmodule // host_bus_model

// >>> tb_demux_host_com_area_port.sv
// Bench for the demultiplexed host port with processor-side stimulus
`timescale 1ns/1ps
module tb_demux_host_com_area_port;
reg mclk = 1'b0;
reg sys_rst = 1'b1;
reg mwr = 1'b0, ack = 1'b0, bclr = 1'b0, iwr = 1'b0;
reg [7:0] mwa = 8'h00, mwd = 8'h00, mra = 8'h00, ivec = 8'h00;
reg [7:0] clo_i = 8'h00, chi_i = 8'h00, shi_i = 8'h00, q, d, e, k;
wire cs, rd, wr, sel, aoe, hang, h2p, hbsy, pbsy, dint;
wire [2:0] al;
wire [7:0] adi, ado, mrd, ivh, clo, chi, mhi;
integer err_total = 0, total_checks = 0, seed = 51;
always #10 mclk = ~mclk;
demux_host_com_area_port dut (.mclk(mclk), .sys_rst(sys_rst),
	.cs_n_pin(cs), .rd_n_pin(rd), .wr_n_pin(wr), .addr_low_pin(al),
	.indirect_select_pin(sel), .ad_in(adi), .ad_out(ado), .ad_oe(aoe),
	.dsp_mbx_wr(mwr), .dsp_mbx_waddr(mwa), .dsp_mbx_wdata(mwd),
	.dsp_mbx_raddr(mra), .dsp_mbx_rdata(mrd), .dsp_h2p_ack(ack),
	.dsp_h2p_busy_clr(bclr), .dsp_p2h_wr(iwr), .dsp_p2h_vec(ivec),
	.host_to_proc_soft_irq(h2p), .h2p_vec(ivh), .host_irq_busy_flag(hbsy),
	.proc_irq_busy_flag(pbsy), .dint_status(dint), .dsp_ctrl_lo(clo_i),
	.dsp_ctrl_hi(chi_i), .irq_status_high(shi_i), .ctrl_h2d_lo(clo),
	.ctrl_h2d_hi(chi), .irq_mask_high(mhi));
host_bus_model host (.mclk(mclk), .cs_n_pin(cs), .rd_n_pin(rd),
	.wr_n_pin(wr), .addr_low_pin(al), .indirect_select_pin(sel),
	.ad_in(adi), .ad_out(ado), .ad_oe(aoe), .hang(hang));
// ----
// Helpers
// ----
task chk(input [7:0] got, input [7:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	end
endtask
task conclude;
	begin
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	end
endtask
task acc(input w, input [3:0] l, input [7:0] v);
	host.access(w, l, v, q);
endtask
// Processor pulse: 0 acknowledge, 1 busy clear, 2 vector load
task proc(input [1:0] s);
	begin
		@(posedge mclk);
		{iwr, bclr, ack} <= 3'b001 << s;
		@(posedge mclk);
		{iwr, bclr, ack} <= 3'b000;
		@(posedge mclk);
	end
endtask
function [7:0] ctl_exp(input [7:0] l, input [7:0] v);
	ctl_exp = l == 8'h05 ? v : l == 8'h06 ? v + 8'h01 : v ^ 8'hf0;
endfunction
always @(posedge hang) begin
	err_total = err_total + 1;
	conclude;
end
initial begin
	repeat (20) @(posedge mclk);
	sys_rst <= 1'b0;
	repeat (4) @(posedge mclk);
	acc(1'b1, 4'h1, 8'hfe);
	for (k = 0; k < 4; k = k + 1) begin
		d = 8'($random(seed));
		acc(1'b1, 4'h2, d);
		mra <= 8'hfe + k;
		repeat (2) @(posedge mclk);
		chk(mrd, d);
	end
	acc(1'b0, 4'h1, 8'h00);
	chk(q, 8'h02);
	for (k = 0; k < 3; k = k + 1) begin
		@(posedge mclk);
		mwr <= 1'b1;
		mwa <= k - 8'h01;
		mwd <= (k - 8'h01) ^ 8'ha5;
	end
	@(posedge mclk);
	mwr <= 1'b0;
	acc(1'b1, 4'h0, 8'hff);
	acc(1'b0, 4'h2, 8'h00);
	chk(q, 8'h5a);
	acc(1'b0, 4'h2, 8'h00);
	chk(q, 8'ha5);
	acc(1'b1, 4'h8, 8'h4c);
	acc(1'b0, 4'h9, 8'h00);
	chk(q, 8'ha4);
	acc(1'b0, 4'h8, 8'h00);
	chk(q, 8'h4c);
	acc(1'b0, 4'h0, 8'h00);
	chk(q, 8'h02);
	d = 8'($random(seed));
	e = 8'($random(seed));
	clo_i <= e;
	chi_i <= e + 8'h01;
	shi_i <= e ^ 8'hf0;
	acc(1'b1, 4'h5, d);
	acc(1'b1, 4'h6, ~d);
	acc(1'b1, 4'h7, d ^ 8'h3c);
	chk(clo, d);
	chk(chi, ~d);
	chk(mhi, d ^ 8'h3c);
	for (k = 5; k < 8; k = k + 1) begin
		acc(1'b0, k[3:0], 8'h00);
		chk(q, ctl_exp(k, e));
	end
	acc(1'b1, 4'h8, 8'h60);
	acc(1'b1, 4'h9, e);
	chk(clo, e);
	acc(1'b1, 4'h8, 8'h61);
	acc(1'b0, 4'h9, 8'h00);
	chk(q, e + 8'h01);
	acc(1'b1, 4'h8, 8'hff);
	acc(1'b0, 4'h9, 8'h00);
	chk(q, 8'h00);
	for (k = 8'h0a; k < 8'h10; k = k + 1) begin
		acc(1'b1, k[3:0], 8'hff);
		acc(1'b0, k[3:0], 8'h00);
		chk(q, 8'h00);
	end
	chk(mhi, d ^ 8'h3c);
	acc(1'b1, 4'h3, d);
	chk(ivh, d);
	chk({6'h00, h2p, hbsy}, 8'h03);
	acc(1'b0, 4'h3, 8'h00);
	chk(q, 8'h01);
	proc(2'd0);
	chk({7'h00, h2p}, 8'h00);
	proc(2'd1);
	acc(1'b0, 4'h3, 8'h00);
	chk(q, 8'h00);
	ivec <= e;
	proc(2'd2);
	chk({6'h00, dint, pbsy}, 8'h03);
	acc(1'b0, 4'h4, 8'h00);
	chk(q, e);
	chk({7'h00, dint}, 8'h00);
	acc(1'b1, 4'h4, 8'h00);
	chk({7'h00, pbsy}, 8'h00);
	conclude;
end
endmodule // tb_demux_host_com_area_port
bind demux_host_com_area_port com_area_props u_props (.mclk(mclk),
	.sys_rst(sys_rst), .cs_n_pin(cs_n_pin), .rd_n_pin(rd_n_pin),
	.wr_n_pin(wr_n_pin), .addr_low_pin(addr_low_pin), .ad_oe(ad_oe),
	.indirect_select_pin(indirect_select_pin), .dsp_h2p_ack(dsp_h2p_ack),
	.dsp_h2p_busy_clr(dsp_h2p_busy_clr), .dsp_p2h_wr(dsp_p2h_wr),
	.host_to_proc_soft_irq(host_to_proc_soft_irq),
	.host_irq_busy_flag(host_irq_busy_flag),
	.proc_irq_busy_flag(proc_irq_busy_flag), .dint_status(dint_status));
